//--- cabe_exec.sv
// execution unit for add, add with carry, arithmetic shift, bit clear,
// bit test and skip, and relative jump
// assumes file read data arrives combinationally for file_addr of this cycle
`timescale 1ns/10ps
`default_nettype none

module cabe_exec (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // decoded instruction
  input wire logic op_valid,
  input wire cabe_pkg::cabe_op_t op_code,
  input wire logic [6:0] op_file_addr,
  input wire logic op_dest,
  input wire logic [2:0] op_bit_sel,
  input wire logic [8:0] op_literal,
  // data memory
  output logic [6:0] file_addr,
  input wire logic [7:0] file_rdata,
  output logic file_we,
  output logic [7:0] file_wdata,
  output logic [6:0] file_waddr,
  // core state
  output logic [7:0] work_reg,
  output logic carry_flag,
  output logic digit_carry_flag,
  output logic zero_flag,
  output logic [14:0] pc,
  output logic flush_cycle
);

  // ==========================================================================
  // arithmetic helpers
  // ==========================================================================
  // nibble-split adder so digit carry and carry come from one place
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin);
    logic [4:0] lo;
    logic [4:0] hi;
    lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    hi = {1'b0, a[7:4]} + {1'b0, b[7:4]} + {4'h0, lo[4]};
    add8 = {hi[4], lo[4], hi[3:0], lo[3:0]};
  endfunction

  // ==========================================================================
  // decode helpers
  // ==========================================================================
  // one place decides whether an op in this slot really runs; a dropped slot
  // must never reach the flags, the file or the counter
  function automatic logic op_is(input cabe_pkg::cabe_op_t code,
                                 input cabe_pkg::cabe_op_t want,
                                 input logic live);
    op_is = live && (code == want);
  endfunction

  // sign-extend the 9-bit offset to the counter width
  function automatic logic [14:0] sext_offset(input logic [8:0] lit);
    sext_offset = {{6{lit[8]}}, lit};
  endfunction

  assign file_addr = op_file_addr;

  logic skip_reg;
  logic skip_next;
  logic jump_reg;
  logic [7:0] result;
  logic [9:0] sum;
  logic writes;
  logic sets_cdz;
  logic sets_cz;
  logic bit_val;
  logic active;
  logic take_jump;

  // ==========================================================================
  // combinational datapath
  // ==========================================================================
  // the second cycle of a taken skip or a jump is the no-op slot: the fetched word is dropped
  assign active = op_valid && !skip_reg && !jump_reg;
  assign take_jump = op_is(op_code, cabe_pkg::CABE_OP_JUMP, active);
  assign bit_val = file_rdata[op_bit_sel];

  always_comb begin
    sum = add8(work_reg, file_rdata, 1'b0);
    result = file_rdata;
    writes = 1'b0;
    sets_cdz = 1'b0;
    sets_cz = 1'b0;
    skip_next = 1'b0;
    if (active) begin
      case (op_code)
        cabe_pkg::CABE_OP_ADD: begin
          result = sum[7:0];
          writes = 1'b1;
          sets_cdz = 1'b1;
        end
        cabe_pkg::CABE_OP_ADDC: begin
          sum = add8(work_reg, file_rdata, carry_flag);
          result = sum[7:0];
          writes = 1'b1;
          sets_cdz = 1'b1;
        end
        cabe_pkg::CABE_OP_ASR: begin
          result = {file_rdata[7], file_rdata[7:1]};
          writes = 1'b1;
          sets_cz = 1'b1;
        end
        cabe_pkg::CABE_OP_BCLR: begin
          result = file_rdata & ~(8'h01 << op_bit_sel);
          writes = 1'b1;
        end
        cabe_pkg::CABE_OP_SKIP_ZERO: skip_next = !bit_val;
        cabe_pkg::CABE_OP_SKIP_ONE: skip_next = bit_val;
        default: begin
        end
      endcase
    end
  end

  // ==========================================================================
  // destination writes
  // ==========================================================================
  // bit clear always targets the file; others follow the destination bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      work_reg <= cabe_pkg::CABE_RESET_WORK;
      file_we <= 1'b0;
      file_wdata <= 8'h00;
      file_waddr <= 7'h00;
    end else begin
      file_we <= 1'b0;
      file_wdata <= result;
      file_waddr <= op_file_addr;
      if (writes) begin
        if (op_code != cabe_pkg::CABE_OP_BCLR && op_dest == cabe_pkg::CABE_DEST_WORK) begin
          work_reg <= result;
        end else begin
          file_we <= 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // status flags
  // ==========================================================================
  // carry: out of bit 7 on adds, old bit 0 on the shift
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      carry_flag <= 1'b0;
    end else if (sets_cdz) begin
      carry_flag <= sum[9];
    end else if (sets_cz) begin
      carry_flag <= file_rdata[0];
    end
  end

  // digit carry: only the adds touch it; the shift leaves it alone
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      digit_carry_flag <= 1'b0;
    end else if (sets_cdz) begin
      digit_carry_flag <= sum[8];
    end
  end

  // zero: every op that moves data through the adder or the shifter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      zero_flag <= 1'b0;
    end else if (sets_cdz || sets_cz) begin
      zero_flag <= (result == 8'h00);
    end
  end

  // ==========================================================================
  // program counter
  // ==========================================================================
  // pc advances every cycle, the dropped slot included; a jump adds its offset
  // to the already stepped value, so the target is pc plus one plus the offset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc <= cabe_pkg::CABE_RESET_PC;
    end else if (take_jump) begin
      pc <= pc + cabe_pkg::CABE_PC_STEP + sext_offset(op_literal);
    end else begin
      pc <= pc + cabe_pkg::CABE_PC_STEP;
    end
  end

  // ==========================================================================
  // no-op slot
  // ==========================================================================
  // the word behind a taken skip or a jump is already in flight, so it is
  // dropped here rather than stalling the decoder
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      skip_reg <= 1'b0;
      jump_reg <= 1'b0;
      flush_cycle <= 1'b0;
    end else begin
      skip_reg <= skip_next;
      jump_reg <= take_jump;
      flush_cycle <= skip_next || take_jump;
    end
  end

endmodule // cabe_exec

`default_nettype wire

//--- cabe_pkg.sv
// package for the arithmetic, bit and branch execution unit
// assumes a decoder that presents one operation per instruction cycle
package cabe_pkg;

  // operation codes presented by the decoder
  typedef enum logic [2:0] {
    CABE_OP_NONE,
    CABE_OP_ADD,
    CABE_OP_ADDC,
    CABE_OP_ASR,
    CABE_OP_BCLR,
    CABE_OP_SKIP_ZERO,
    CABE_OP_SKIP_ONE,
    CABE_OP_JUMP
  } cabe_op_t;

  localparam int CABE_DATA_W = 8;
  localparam int CABE_ADDR_W = 7;
  localparam int CABE_PC_W = 15;
  localparam int CABE_LIT_W = 9;
  localparam int CABE_DIGIT_POS = 4;
  localparam logic CABE_DEST_WORK = 1'h0;
  localparam logic [7:0] CABE_RESET_WORK = 8'h00;
  localparam logic [14:0] CABE_RESET_PC = 15'h0000;
  localparam logic [14:0] CABE_PC_STEP = 15'h0001;

endpackage : cabe_pkg

//--- cabe_exec_monitor.sv
// checks on cabe_exec relations, bound to its ports
// assumes one clock domain and a one-cycle registered answer
`timescale 1ns/10ps
`default_nettype none
module cabe_exec_monitor (
  // every port of cabe_exec, watched only
  input wire logic clk, rst, op_valid, op_dest, file_we, flush_cycle,
  input wire logic carry_flag, digit_carry_flag, zero_flag,
  input var cabe_pkg::cabe_op_t op_code,
  input wire logic [6:0] op_file_addr, file_addr, file_waddr,
  input wire logic [2:0] op_bit_sel,
  input wire logic [8:0] op_literal,
  input wire logic [7:0] file_rdata, file_wdata, work_reg,
  input wire logic [14:0] pc
);
  // an op in the flush slot is dropped, so nothing below may count it
  wire tk = op_valid & !flush_cycle;
  wire ci = op_code == cabe_pkg::CABE_OP_ADDC & carry_flag;
  wire a = tk & (op_code == cabe_pkg::CABE_OP_ADD | op_code == cabe_pkg::CABE_OP_ADDC);
  wire sr = tk & op_code == cabe_pkg::CABE_OP_ASR;
  wire bz = tk & op_code == cabe_pkg::CABE_OP_BCLR;
  wire jp = tk & op_code == cabe_pkg::CABE_OP_JUMP;
  wire k = tk & (op_code == cabe_pkg::CABE_OP_SKIP_ZERO | op_code == cabe_pkg::CABE_OP_SKIP_ONE);
  wire kt = (op_code == cabe_pkg::CABE_OP_SKIP_ZERO) ^ file_rdata[op_bit_sel];
  wire [8:0] s = work_reg + file_rdata + ci;
  wire h = work_reg[3:0] + file_rdata[3:0] + ci > 5'h0F;
  wire b0 = file_rdata[0];
  wire [7:0] bc = file_rdata & ~(8'h01 << op_bit_sel);
  wire [14:0] j = {{6{op_literal[8]}}, op_literal};
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_aw; a & !op_dest |=> {carry_flag, work_reg} == $past(s); endproperty
  a_aw: assert property (p_aw) else $error("add into work wrong");
  property p_af; a & op_dest |=> file_we && {carry_flag, file_wdata} == $past(s); endproperty
  a_af: assert property (p_af) else $error("add into file wrong");
  property p_dc; a |=> digit_carry_flag == $past(h); endproperty
  a_dc: assert property (p_dc) else $error("digit carry wrong");
  property p_sr; sr |=> carry_flag == $past(b0) && file_we == $past(op_dest); endproperty
  a_sr: assert property (p_sr) else $error("shift wrong");
  property p_bc; bz |=> file_we && file_wdata == $past(bc) && $stable(zero_flag); endproperty
  a_bc: assert property (p_bc) else $error("bit clear wrong");
  property p_sk; k |=> flush_cycle == $past(kt) && $stable(carry_flag); endproperty
  a_sk: assert property (p_sk) else $error("skip wrong");
  property p_jp; jp |=> pc == $past(pc) + 15'h0001 + $past(j) ##1 !flush_cycle; endproperty
  a_jp: assert property (p_jp) else $error("jump wrong");
  property p_fl; flush_cycle |=> !file_we && !flush_cycle; endproperty
  a_fl: assert property (p_fl) else $error("flush slot not dropped");
endmodule // cabe_exec_monitor
bind cabe_exec cabe_exec_monitor cabe_exec_monitor_i (.*);
`default_nettype wire

//--- cabe_exec_test.sv
// bench for cabe_exec: directed ops judged against worked values
// assumes the bound monitor watches timing and pc relations
`timescale 1ns/10ps
`default_nettype none
module cabe_exec_test;
  logic clk = 0, rst = 1, op_valid = 0, op_dest = 0, file_we, flush_cycle;
  logic carry_flag, digit_carry_flag, zero_flag;
  cabe_pkg::cabe_op_t op_code = cabe_pkg::CABE_OP_NONE;
  logic [6:0] op_file_addr = 0, file_addr, file_waddr;
  logic [2:0] op_bit_sel = 0;
  logic [8:0] op_literal = 0;
  logic [7:0] file_rdata = 0, file_wdata, work_reg;
  logic [14:0] pc, p;
  wire [12:0] st = {file_we, flush_cycle, carry_flag, digit_carry_flag, zero_flag, work_reg};
  int fail_count = 0, check_count = 0;
  cabe_exec cabe_exec_i (.*);
  initial forever #25 clk = !clk;
  task automatic chk(input logic [23:0] s, e);
    check_count++;
    if (s !== e) begin
      fail_count++;
      $display("unexpected at %0t seen %h expected %h", $time, s, e);
    end
  endtask
  // one op per call; nv keeps op_valid up into the following slot
  task automatic go(input cabe_pkg::cabe_op_t c, input logic d, input logic [2:0] b,
      input logic [8:0] l, input logic [7:0] r, input logic nv);
    @(negedge clk);
    op_code = c;
    op_dest = d;
    op_bit_sel = b;
    op_literal = l;
    file_rdata = r;
    op_file_addr = r[6:0];
    op_valid = 1'h1;
    @(negedge clk);
    op_valid = nv;
  endtask
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (16) @(negedge clk);
    rst = 0;
    chk(st, 13'h0000);
    go(cabe_pkg::CABE_OP_ADD, 1'h0, 3'h0, 9'h000, 8'h8F, 1'h0);
    chk(st, 13'h008F);
    go(cabe_pkg::CABE_OP_ADD, 1'h0, 3'h0, 9'h000, 8'h71, 1'h0);
    chk(st, 13'h0700);
    go(cabe_pkg::CABE_OP_ADDC, 1'h1, 3'h0, 9'h000, 8'h0F, 1'h0);
    chk({st, file_wdata}, {13'h1200, 8'h10});
    chk(file_waddr, 7'h0F);
    go(cabe_pkg::CABE_OP_ASR, 1'h0, 3'h0, 9'h000, 8'h81, 1'h0);
    chk(st, 13'h06C0);
    go(cabe_pkg::CABE_OP_ASR, 1'h1, 3'h0, 9'h000, 8'h01, 1'h0);
    chk({st, file_wdata}, {13'h17C0, 8'h00});
    for (int i = 0; i < 8; i++) begin
      go(cabe_pkg::CABE_OP_BCLR, 1'h0, i[2:0], 9'h000, 8'hFF, 1'h0);
      chk({st, file_wdata}, {13'h17C0, 8'hFF ^ (8'h01 << i)});
    end
    for (int i = 0; i < 4; i++) begin
      go(i[1] ? cabe_pkg::CABE_OP_SKIP_ONE : cabe_pkg::CABE_OP_SKIP_ZERO, 1'h0, 3'h2,
        9'h000, i[0] ? 8'h04 : 8'h00, 1'h0);
      chk(st, i[1] == i[0] ? 13'h0FC0 : 13'h07C0);
    end
    p = pc + 15'h7F02;
    go(cabe_pkg::CABE_OP_JUMP, 1'h0, 3'h0, 9'h100, 8'h00, 1'h1);
    chk(pc, p);
    chk(st, 13'h0FC0);
    go(cabe_pkg::CABE_OP_ADD, 1'h1, 3'h0, 9'h000, 8'h40, 1'h0);
    chk({st, file_wdata}, {13'h15C0, 8'h00});
    chk(file_addr, 7'h40);
    end_of_test;
  end
endmodule // cabe_exec_test
`default_nettype wire
